/* File: mcoc_map.svh */
// Purpose: offsets, field positions and reset values of the macrocell config block
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef MCOC_MAP_SVH
`define MCOC_MAP_SVH
`define MCOC_OFS_GLOBAL 8'h00
`define MCOC_OFS_LOCAL 8'h04
`define MCOC_OFS_CTRL 8'h08
`define MCOC_OFS_STATUS 8'h0C
`define MCOC_OFS_SIG_LO 8'h10
`define MCOC_OFS_SIG_HI 8'h14
`define MCOC_GLB_PERMIT_BIT 0
`define MCOC_GLB_EMUL_BIT 1
`define MCOC_LOC_MODE_LSB 0
`define MCOC_LOC_POL_LSB 8
`define MCOC_CTL_PRELOAD_MODE_BIT 0
`define MCOC_CTL_PRELOAD_LOAD_BIT 1
`define MCOC_CTL_SECURE_BIT 2
`define MCOC_CTL_ERASE_BIT 3
`define MCOC_STA_SECURE_BIT 0
`define MCOC_STA_REJECT_BIT 1
`define MCOC_STA_PRELOAD_BIT 2
`define MCOC_STA_STATE_LSB 8
`define MCOC_RST_PERMIT 1'h1
`define MCOC_RST_EMUL 1'h0
`define MCOC_RST_MODE 8'hFF
`define MCOC_RST_POL 8'h00
`define MCOC_RST_SIG 32'h00000000
`endif

/* File: mcoc_pkg.sv */
// Purpose: types of the macrocell config block
// Assumes: eight macrocells of eight product terms
// Notes: constants live in mcoc_map.svh
package mcoc_pkg;
    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } mcoc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } mcoc_apb_rsp_t;

    typedef struct packed {
        logic [7:0] io_out;
        logic [7:0] io_oe_n;
        logic [7:0] fb;
        logic array_clk;
        logic array_oe;
    } mcoc_pins_t;

    typedef enum logic [2:0] {
        MCOC_REGISTERED = 3'b000,
        MCOC_COMB_IO_REG = 3'b001,
        MCOC_COMB_OUT = 3'b010,
        MCOC_DED_INPUT = 3'b011,
        MCOC_COMB_IO = 3'b100,
        MCOC_UNSUPPORTED = 3'b111
    } mcoc_mode_t;
endpackage : mcoc_pkg

/* File: mcoc_sig_mem.sv */
// Purpose: signature word storage with registered read
// Assumes: one write port, one read port, clear of all words at once
// Notes: read data appear one cycle after rd_en
`timescale 1ns/100ps
module mcoc_sig_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic clr,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_word
            always_ff @(posedge clk)
            begin
                if (srst || clr)
                    mem_q[gi] <= RST_VAL;
                else if (wr_en && wr_addr == gi)
                    mem_q[gi] <= wr_data;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (srst)
            rd_data <= '0;
        else if (rd_en)
            rd_data <= mem_q[rd_addr];
    end
endmodule : mcoc_sig_mem

/* File: mcoc_top.sv */
// Purpose: eight configurable output macrocells with apb programming port
// Assumes: product terms come from an external and-array, pins sampled on clk
// Notes: clk_pin rising edge is a one-cycle enable, no second clock
//
// Contract
// - mode 1,0,1 is dedicated input, adjacent feedback
// - mode 1,1,1: seven terms, eighth enables buffer
// - non-registered comb io feeds pin back
// - mode 0,1,1: seven terms, eighth enable, pin feedback
// - polarity bit xors sum, 1 is active low
// - edge cells in comb output have no feedback
// - all cell flops clear low at reset
// - registered outputs read high after reset
// - flops preload from levels on output pins
// - secure device refuses config readback
// - secure bit clears only with reset or full erase
// - holds 64-bit user signature word
// - signature readable whatever the secure bit
// - mode 0,1,0 registered, oe pin, inverted feedback
// - mode 1,0,0 comb output, enabled except in preload mode
// - edge cell feedback steered by inverted permit
// - clk and oe pins reach array only unregistered
`timescale 1ns/100ps
`include "mcoc_map.svh"
module mcoc_top #(
    parameter int CELLS = 8,
    parameter int TERMS = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire mcoc_pkg::mcoc_apb_req_t apb_req,
    output mcoc_pkg::mcoc_apb_rsp_t apb_rsp,
    input wire logic [CELLS-1:0][TERMS-1:0] product_terms,
    input wire logic [CELLS-1:0] io_in,
    input wire logic clk_pin,
    input wire logic oe_pin_n,
    output mcoc_pkg::mcoc_pins_t pins
);
    logic register_permit_global_q;
    logic emulation_select_global_q;
    logic [CELLS-1:0] cell_mode_local_q;
    logic [CELLS-1:0] polarity_local_q;
    logic secure_q;
    logic reject_q;
    logic preload_mode_q;
    logic [CELLS-1:0] cell_q;
    logic clk_pin_q;
    logic clk_rise;
    logic setup;
    logic access;
    logic wr;
    logic [31:0] sig_rd;
    logic sig_hit;
    logic mapped;
    logic glb_ok;
    logic loc_ok;
    logic erase;
    mcoc_pkg::mcoc_mode_t mode [CELLS];
    logic [CELLS-1:0] sop;
    logic [CELLS-1:0] comb_oe;
    logic [CELLS-1:0] io_out_d;
    logic [CELLS-1:0] oe_n_d;
    logic [CELLS-1:0] fb_d;

    function automatic mcoc_pkg::mcoc_mode_t cell_mode_of(input logic permit, input logic emul, input logic m);
        mcoc_pkg::mcoc_mode_t r;
        r = mcoc_pkg::MCOC_UNSUPPORTED;
        if (!permit && emul && !m)
            r = mcoc_pkg::MCOC_REGISTERED;
        else if (!permit && emul && m)
            r = mcoc_pkg::MCOC_COMB_IO_REG;
        else if (permit && !emul && !m)
            r = mcoc_pkg::MCOC_COMB_OUT;
        else if (permit && !emul && m)
            r = mcoc_pkg::MCOC_DED_INPUT;
        else if (permit && emul && m)
            r = mcoc_pkg::MCOC_COMB_IO;
        return r;
    endfunction : cell_mode_of

    function automatic logic all_ok(input logic permit, input logic emul, input logic [CELLS-1:0] m);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < CELLS; i++)
        begin
            if (cell_mode_of(permit, emul, m[i]) == mcoc_pkg::MCOC_UNSUPPORTED)
                ok = 1'b0;
        end
        return ok;
    endfunction : all_ok

    // apb decode
    assign setup = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable;
    assign wr = access && apb_req.pwrite;
    assign erase = wr && apb_req.paddr == `MCOC_OFS_CTRL && apb_req.pwdata[`MCOC_CTL_ERASE_BIT];
    assign sig_hit = apb_req.paddr == `MCOC_OFS_SIG_LO || apb_req.paddr == `MCOC_OFS_SIG_HI;
    assign glb_ok = all_ok(apb_req.pwdata[`MCOC_GLB_PERMIT_BIT], apb_req.pwdata[`MCOC_GLB_EMUL_BIT],
                           cell_mode_local_q);
    assign loc_ok = all_ok(register_permit_global_q, emulation_select_global_q,
                           apb_req.pwdata[`MCOC_LOC_MODE_LSB +: CELLS]);

    always_comb
    begin
        mapped = 1'b0;
        if (apb_req.paddr == `MCOC_OFS_GLOBAL)
            mapped = 1'b1;
        else if (apb_req.paddr == `MCOC_OFS_LOCAL)
            mapped = 1'b1;
        else if (apb_req.paddr == `MCOC_OFS_CTRL)
            mapped = 1'b1;
        else if (apb_req.paddr == `MCOC_OFS_STATUS)
            mapped = 1'b1;
        else if (sig_hit)
            mapped = 1'b1;
    end

    // global configuration bits
    always_ff @(posedge clk)
    begin
        if (srst || erase)
        begin
            register_permit_global_q <= `MCOC_RST_PERMIT;
            emulation_select_global_q <= `MCOC_RST_EMUL;
        end
        else if (wr && apb_req.paddr == `MCOC_OFS_GLOBAL && !secure_q && glb_ok)
        begin
            register_permit_global_q <= apb_req.pwdata[`MCOC_GLB_PERMIT_BIT];
            emulation_select_global_q <= apb_req.pwdata[`MCOC_GLB_EMUL_BIT];
        end
    end

    // local configuration bits
    always_ff @(posedge clk)
    begin
        if (srst || erase)
        begin
            cell_mode_local_q <= `MCOC_RST_MODE;
            polarity_local_q <= `MCOC_RST_POL;
        end
        else if (wr && apb_req.paddr == `MCOC_OFS_LOCAL && !secure_q && loc_ok)
        begin
            cell_mode_local_q <= apb_req.pwdata[`MCOC_LOC_MODE_LSB +: CELLS];
            polarity_local_q <= apb_req.pwdata[`MCOC_LOC_POL_LSB +: CELLS];
        end
    end

    // secure bit, only srst or an erase clears it
    always_ff @(posedge clk)
    begin
        if (srst)
            secure_q <= 1'b0;
        else if (erase)
            secure_q <= 1'b0;
        else if (wr && apb_req.paddr == `MCOC_OFS_CTRL && apb_req.pwdata[`MCOC_CTL_SECURE_BIT])
            secure_q <= 1'b1;
    end

    // rejected configuration flag, write one to clear, set wins
    always_ff @(posedge clk)
    begin
        if (srst)
            reject_q <= 1'b0;
        else if (wr && ((apb_req.paddr == `MCOC_OFS_GLOBAL && !glb_ok) ||
                        (apb_req.paddr == `MCOC_OFS_LOCAL && !loc_ok)))
            reject_q <= 1'b1;
        else if (wr && apb_req.paddr == `MCOC_OFS_STATUS && apb_req.pwdata[`MCOC_STA_REJECT_BIT])
            reject_q <= 1'b0;
    end

    // preload mode releases all buffers so a tester can drive pins
    always_ff @(posedge clk)
    begin
        if (srst)
            preload_mode_q <= 1'b0;
        else if (wr && apb_req.paddr == `MCOC_OFS_CTRL)
            preload_mode_q <= apb_req.pwdata[`MCOC_CTL_PRELOAD_MODE_BIT];
    end

    // clock pin edge as enable
    always_ff @(posedge clk)
    begin
        if (srst)
            clk_pin_q <= 1'b0;
        else
            clk_pin_q <= clk_pin;
    end
    assign clk_rise = clk_pin && !clk_pin_q;

    // signature storage
    mcoc_sig_mem #(
        .WIDTH(32),
        .DEPTH(2),
        .RST_VAL(`MCOC_RST_SIG)
    ) u_sig (
        .clk(clk),
        .srst(srst),
        .clr(erase),
        .wr_en(wr && sig_hit),
        .wr_addr(apb_req.paddr[2]),
        .wr_data(apb_req.pwdata),
        .rd_en(setup && sig_hit),
        .rd_addr(apb_req.paddr[2]),
        .rd_data(sig_rd)
    );

    // per-cell datapath
    genvar gi;
    generate
        for (gi = 0; gi < CELLS; gi++)
        begin : g_cell
            localparam int ADJ = (gi == CELLS - 1) ? gi - 1 : gi + 1;
            localparam bit EDGE = (gi == 0) || (gi == CELLS - 1);

            assign mode[gi] = cell_mode_of(register_permit_global_q, emulation_select_global_q,
                                           cell_mode_local_q[gi]);

            always_comb
            begin
                sop[gi] = |product_terms[gi];
                comb_oe[gi] = 1'b1;
                if (cell_mode_local_q[gi])
                begin
                    sop[gi] = |product_terms[gi][TERMS-2:0];
                    comb_oe[gi] = product_terms[gi][TERMS-1];
                end
            end

            // flop holds inverted data so reset low shows high on the pin
            always_ff @(posedge clk)
            begin
                if (srst)
                    cell_q[gi] <= 1'b0;
                else if (preload_mode_q && wr && apb_req.paddr == `MCOC_OFS_CTRL &&
                         apb_req.pwdata[`MCOC_CTL_PRELOAD_LOAD_BIT])
                    cell_q[gi] <= !io_in[gi];
                else if (mode[gi] == mcoc_pkg::MCOC_REGISTERED && clk_rise)
                    cell_q[gi] <= !(sop[gi] ^ polarity_local_q[gi]);
            end

            always_comb
            begin
                io_out_d[gi] = sop[gi] ^ polarity_local_q[gi];
                oe_n_d[gi] = 1'b1;
                fb_d[gi] = 1'b0;
                case (mode[gi])
                    mcoc_pkg::MCOC_REGISTERED:
                    begin
                        io_out_d[gi] = !cell_q[gi];
                        oe_n_d[gi] = oe_pin_n;
                        fb_d[gi] = !cell_q[gi];
                    end
                    mcoc_pkg::MCOC_COMB_IO_REG:
                    begin
                        oe_n_d[gi] = !comb_oe[gi];
                        fb_d[gi] = io_in[gi];
                    end
                    mcoc_pkg::MCOC_COMB_OUT:
                    begin
                        oe_n_d[gi] = 1'b0;
                        fb_d[gi] = EDGE ? (!register_permit_global_q && io_in[gi]) : io_in[gi];
                    end
                    mcoc_pkg::MCOC_DED_INPUT:
                    begin
                        oe_n_d[gi] = 1'b1;
                        fb_d[gi] = io_in[ADJ];
                    end
                    mcoc_pkg::MCOC_COMB_IO:
                    begin
                        oe_n_d[gi] = !comb_oe[gi];
                        fb_d[gi] = io_in[gi];
                    end
                    default:
                    begin
                        oe_n_d[gi] = 1'b1;
                        fb_d[gi] = 1'b0;
                    end
                endcase
                if (preload_mode_q)
                    oe_n_d[gi] = 1'b1;
            end
        end
    endgenerate

    assign pins.io_out = io_out_d;
    assign pins.io_oe_n = oe_n_d;
    assign pins.fb = fb_d;
    assign pins.array_clk = !register_permit_global_q ? 1'b0 : clk_pin;
    assign pins.array_oe = !register_permit_global_q ? 1'b0 : !oe_pin_n;

    // read mux, config hidden once secure
    always_comb
    begin
        apb_rsp.prdata = 32'h00000000;
        if (!access || apb_req.pwrite)
            apb_rsp.prdata = 32'h00000000;
        else if (apb_req.paddr == `MCOC_OFS_GLOBAL)
        begin
            if (!secure_q)
            begin
                apb_rsp.prdata[`MCOC_GLB_PERMIT_BIT] = register_permit_global_q;
                apb_rsp.prdata[`MCOC_GLB_EMUL_BIT] = emulation_select_global_q;
            end
        end
        else if (apb_req.paddr == `MCOC_OFS_LOCAL)
        begin
            if (!secure_q)
            begin
                apb_rsp.prdata[`MCOC_LOC_MODE_LSB +: CELLS] = cell_mode_local_q;
                apb_rsp.prdata[`MCOC_LOC_POL_LSB +: CELLS] = polarity_local_q;
            end
        end
        else if (apb_req.paddr == `MCOC_OFS_CTRL)
            apb_rsp.prdata[`MCOC_CTL_PRELOAD_MODE_BIT] = preload_mode_q;
        else if (apb_req.paddr == `MCOC_OFS_STATUS)
        begin
            apb_rsp.prdata[`MCOC_STA_SECURE_BIT] = secure_q;
            apb_rsp.prdata[`MCOC_STA_REJECT_BIT] = reject_q;
            apb_rsp.prdata[`MCOC_STA_PRELOAD_BIT] = preload_mode_q;
            apb_rsp.prdata[`MCOC_STA_STATE_LSB +: CELLS] = ~cell_q;
        end
        else if (sig_hit)
            apb_rsp.prdata = sig_rd;
    end

    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = access && !mapped;
endmodule : mcoc_top

/* File: mcoc_board.sv */
// Purpose: board side of the macrocell pins
// Assumes: board drives every pin the block releases
// Notes: no contention, board yields where oe_n is low
`timescale 1ns/100ps
module mcoc_board (
    input wire mcoc_pkg::mcoc_pins_t pins,
    input wire logic [7:0] bd,
    output logic [7:0] io_in
);
    // pin level fed back; board value on released pins
    assign io_in = (pins.io_out & ~pins.io_oe_n) | (bd & pins.io_oe_n);
endmodule : mcoc_board

/* File: mcoc_monitor.sv */
// Purpose: port checks of the macrocell config block
// Assumes: zero wait apb, secure and signature shadowed from writes
// Notes: bound into mcoc_top
`timescale 1ns/100ps
`include "mcoc_map.svh"
module mcoc_monitor #(
    parameter int CELLS = 8,
    parameter int TERMS = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire mcoc_pkg::mcoc_apb_req_t apb_req,
    input wire mcoc_pkg::mcoc_apb_rsp_t apb_rsp,
    input wire logic [CELLS-1:0][TERMS-1:0] product_terms,
    input wire logic [CELLS-1:0] io_in,
    input wire logic clk_pin,
    input wire logic oe_pin_n,
    input wire mcoc_pkg::mcoc_pins_t pins
);
    logic wr;
    logic rd;
    logic ctl;
    logic sec_q;
    logic [31:0] lo_q;
    logic [31:0] hi_q;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    assign ctl = wr && apb_req.paddr == `MCOC_OFS_CTRL;
    always_ff @(posedge clk)
    begin
        if (srst || (ctl && apb_req.pwdata[`MCOC_CTL_ERASE_BIT]))
            sec_q <= 1'b0;
        else if (ctl && apb_req.pwdata[`MCOC_CTL_SECURE_BIT])
            sec_q <= 1'b1;
    end
    always_ff @(posedge clk)
    begin
        if (srst || (ctl && apb_req.pwdata[`MCOC_CTL_ERASE_BIT]))
        begin
            lo_q <= `MCOC_RST_SIG;
            hi_q <= `MCOC_RST_SIG;
        end
        else if (wr && apb_req.paddr == `MCOC_OFS_SIG_LO)
            lo_q <= apb_req.pwdata;
        else if (wr && apb_req.paddr == `MCOC_OFS_SIG_HI)
            hi_q <= apb_req.pwdata;
    end
    a_blank_oe: assert property (@(posedge clk) disable iff (srst)
        $fell(srst) |-> pins.io_oe_n == 8'hFF) else $error("buffers not released after reset");
    a_blank_fb: assert property (@(posedge clk) disable iff (srst)
        $fell(srst) |-> pins.fb == {io_in[6], io_in[7:1]}) else $error("feedback not from adjacent pin");
    a_clk_gate: assert property (@(posedge clk) disable iff (srst)
        pins.array_clk |-> clk_pin) else $error("array clock without clock pin");
    a_oe_gate: assert property (@(posedge clk) disable iff (srst)
        pins.array_oe |-> !oe_pin_n) else $error("array enable without enable pin");
    a_sig_lo_read: assert property (@(posedge clk) disable iff (srst)
        rd && apb_req.paddr == `MCOC_OFS_SIG_LO |-> apb_rsp.prdata == lo_q) else $error("low signature wrong");
    a_sig_hi_read: assert property (@(posedge clk) disable iff (srst)
        rd && apb_req.paddr == `MCOC_OFS_SIG_HI |-> apb_rsp.prdata == hi_q) else $error("high signature wrong");
    a_secure_hide: assert property (@(posedge clk) disable iff (srst)
        rd && sec_q && apb_req.paddr inside {`MCOC_OFS_GLOBAL, `MCOC_OFS_LOCAL} |-> apb_rsp.prdata == 32'h0)
        else $error("config readable while secure");
    a_secure_flag: assert property (@(posedge clk) disable iff (srst)
        rd && apb_req.paddr == `MCOC_OFS_STATUS |-> apb_rsp.prdata[`MCOC_STA_SECURE_BIT] == sec_q)
        else $error("secure flag wrong");
endmodule : mcoc_monitor
bind mcoc_top mcoc_monitor #(.CELLS(CELLS), .TERMS(TERMS)) u_mon (.clk(clk), .srst(srst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .product_terms(product_terms), .io_in(io_in),
    .clk_pin(clk_pin), .oe_pin_n(oe_pin_n), .pins(pins));

/* File: testbench.sv */
// Purpose: self-checking bench of the macrocell config block
// Assumes: zero wait apb, board model on the pins
// Notes: one task per scenario
`timescale 1ns/100ps
`include "mcoc_map.svh"
module testbench;
    localparam logic [7:0] GLB = `MCOC_OFS_GLOBAL;
    localparam logic [7:0] LOC = `MCOC_OFS_LOCAL;
    localparam logic [7:0] CTL = `MCOC_OFS_CTRL;
    localparam logic [7:0] STA = `MCOC_OFS_STATUS;
    logic clk = 1'b0;
    logic srst = 1'b1;
    mcoc_pkg::mcoc_apb_req_t req = '0;
    mcoc_pkg::mcoc_apb_rsp_t rsp;
    logic [7:0][7:0] pt = '0;
    logic [7:0] io_in;
    logic [7:0] bd = 8'h5A;
    logic clk_pin = 1'b0;
    logic oe_pin_n = 1'b1;
    mcoc_pkg::mcoc_pins_t pins;
    logic [31:0] r;
    logic e;
    int mismatches = 0;
    int n_tests = 0;
    always #20 clk = ~clk;
    mcoc_top u_dut (.clk(clk), .srst(srst), .apb_req(req), .apb_rsp(rsp), .product_terms(pt),
        .io_in(io_in), .clk_pin(clk_pin), .oe_pin_n(oe_pin_n), .pins(pins));
    mcoc_board u_board (.pins(pins), .bd(bd), .io_in(io_in));
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        @(posedge clk);
        req.penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge clk);
            if (rsp.pready === 1'b1)
                break;
        end
        if (n == 16)
        begin
            mismatches++;
            final_report();
        end
        else
        begin
            r = rsp.prdata;
            e = rsp.pslverr;
            req.psel <= 1'b0;
            req.penable <= 1'b0;
        end
    endtask : apb
    task automatic t_reset;
        apb(GLB, 1'b0, '0);
        check(r, 32'h00000001);
        apb(STA, 1'b0, '0);
        check(r, 32'h0000FF00);
        check(32'(pins.io_oe_n), 32'hFF);
        check(32'(pins.fb), 32'h000000AD);
    endtask : t_reset
    task automatic t_comb_out;
        apb(LOC, 1'b1, 32'h00003C00);
        for (int i = 0; i < 8; i++)
            pt[i] <= (i % 2 == 0) ? 8'h80 >> i : 8'h00;
        clk_pin <= 1'b1;
        oe_pin_n <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        check(32'(pins.io_out), 32'h69);
        check(32'(pins.io_oe_n), 32'h00);
        check(32'(pins.fb), 32'h68);
        check(32'(pins.array_clk), 32'h1);
        check(32'(pins.array_oe), 32'h1);
    endtask : t_comb_out
    task automatic t_comb_io;
        apb(LOC, 1'b1, 32'h000000FF);
        apb(GLB, 1'b1, 32'h00000003);
        for (int i = 0; i < 8; i++)
            pt[i] <= {i % 2 == 0, 6'h00, i < 4};
        clk_pin <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        check(32'(pins.io_out), 32'h0F);
        check(32'(pins.io_oe_n), 32'hAA);
        check(32'(pins.fb), 32'h0F);
    endtask : t_comb_io
    task automatic t_reg;
        apb(GLB, 1'b1, 32'h00000002);
        @(posedge clk);
        check(32'(pins.io_oe_n), 32'hAA);
        check(32'(pins.fb), 32'h0F);
        apb(LOC, 1'b1, 32'h000000F0);
        oe_pin_n <= 1'b0;
        pt[1] <= 8'h00;
        pt[3] <= 8'h00;
        @(posedge clk);
        @(posedge clk);
        check(32'(pins.io_out[3:0]), 32'hF);
        check(32'(pins.io_oe_n[3:0]), 32'h0);
        clk_pin <= 1'b1;
        repeat (3) @(posedge clk);
        check(32'(pins.array_clk), 32'h0);
        check(32'(pins.array_oe), 32'h0);
        check(32'(pins.io_out[3:0]), 32'h5);
        check(32'(pins.fb[3:0]), 32'h5);
        oe_pin_n <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        check(32'(pins.io_oe_n[3:0]), 32'hF);
        apb(CTL, 1'b1, 32'h00000001);
        bd <= 8'hC3;
        @(posedge clk);
        check(32'(pins.io_oe_n), 32'hFF);
        apb(CTL, 1'b1, 32'h00000003);
        apb(STA, 1'b0, '0);
        check(32'(r[15:8]), 32'hC3);
        apb(CTL, 1'b1, 32'h00000000);
        oe_pin_n <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        check(32'(pins.io_out[3:0]), 32'h3);
    endtask : t_reg
    task automatic t_reject;
        apb(GLB, 1'b1, 32'h00000000);
        apb(GLB, 1'b0, '0);
        check(r, 32'h00000002);
        apb(STA, 1'b0, '0);
        check(32'(r[1]), 32'h1);
        apb(STA, 1'b1, 32'h00000002);
        apb(STA, 1'b0, '0);
        check(32'(r[1]), 32'h0);
    endtask : t_reject
    task automatic t_secure;
        apb(`MCOC_OFS_SIG_LO, 1'b1, 32'hA5A55A5A);
        apb(`MCOC_OFS_SIG_HI, 1'b1, 32'h0F1E2D3C);
        apb(CTL, 1'b1, 32'h00000004);
        apb(LOC, 1'b0, '0);
        check(r, 32'h0);
        apb(CTL, 1'b1, 32'h00000000);
        apb(STA, 1'b1, 32'h00000001);
        apb(STA, 1'b0, '0);
        check(32'(r[0]), 32'h1);
        apb(`MCOC_OFS_SIG_HI, 1'b0, '0);
        check(r, 32'h0F1E2D3C);
        apb(CTL, 1'b1, 32'h00000008);
        apb(LOC, 1'b0, '0);
        check(r, 32'h000000FF);
        apb(`MCOC_OFS_SIG_LO, 1'b0, '0);
        check(r, 32'h0);
        check(32'(pins.io_oe_n), 32'hFF);
        apb(8'h20, 1'b0, '0);
        check({r[30:0], e}, 32'h1);
    endtask : t_secure
    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_comb_out();
        t_comb_io();
        t_reg();
        t_reject();
        t_secure();
        final_report();
    end
endmodule : testbench
